/* rcpm_monitor.sv */
// Reference clock period monitor: hardware capture and pin counting variants.
// Assumes an APB master on ref_clk; reference inputs are asynchronous pins.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/100ps

module rcpm_monitor
  import rcpm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic low_speed_osc_clock,
  input wire logic sub_clock,
  input wire logic ext_capture_input,
  input wire logic [RCPM_NPINS-1:0] reference_input_pin,
  output logic irq
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [RCPM_NPINS+2:0] sync1_q, sync2_q;
  logic cap_pending;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {ext_capture_input, sub_clock, low_speed_osc_clock, reference_input_pin};
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic ctrl_mode_q;
  logic [RCPM_SRC_W-1:0] ctrl_src_q;
  logic [RCPM_PIN_W-1:0] ctrl_pin_q;
  logic [15:0] hw_lower_q, hw_upper_q, sw_lower_q, sw_upper_q;
  logic [RCPM_TMO_W-1:0] timeout_q;
  logic [1:0] result_q;
  logic [RCPM_CNT_W-1:0] value_q;
  logic [1:0] irq_stat_q, irq_mask_q;
  logic capture_flag_q;
  // Limits and control are frozen while a measurement runs, so the
  // window used by the judge is always the one the run started with.

  rcpm_state_t state_q, state_d;
  logic [RCPM_CNT_W-1:0] cnt_q;
  logic [2:0] loop_q;
  logic [RCPM_TMO_W-1:0] wait_q;

  // Selected capture source and pin
  logic src_lvl;
  logic pin_lvl;
  assign src_lvl = (ctrl_src_q == RCPM_SRC_LOW_SPEED_OSC) ? sync2_q[RCPM_NPINS] :
                   (ctrl_src_q == RCPM_SRC_SUB_CLOCK) ? sync2_q[RCPM_NPINS+1] :
                   sync2_q[RCPM_NPINS+2];
  assign pin_lvl = sync2_q[ctrl_pin_q];

  // Edge detection on the synchronised levels
  // Previous levels reset low, matching the idle pins, so no false edge
  // appears right after reset.
  logic src_prev_q, pin_prev_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      src_prev_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src_lvl;
      pin_prev_q <= pin_lvl;
    end
  end
  logic cap_evt, pin_rise, pin_fall;
  assign cap_evt = src_lvl & ~src_prev_q;
  assign pin_rise = pin_lvl & ~pin_prev_q;
  assign pin_fall = ~pin_lvl & pin_prev_q;
  // Capture event waiting to be consumed, shown in status
  assign cap_pending = capture_flag_q;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic wr_en, rd_setup, addr_ok;
  logic [7:0] offs;
  assign offs = paddr[7:0];
  assign addr_ok = (paddr[31:8] == 24'h000000) && (offs[1:0] == 2'h0) && (offs <= RCPM_IRQ_MASK_OFF);
  assign wr_en = psel & penable & pwrite & addr_ok;
  // Read data latched in setup, so zero wait states suffice
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  logic start_wr;
  assign start_wr = wr_en && (offs == RCPM_CTRL_OFF) && pwdata[RCPM_CTRL_START_BIT];
  logic busy;
  // Busy blocks configuration writes; interrupt registers stay writable
  assign busy = (state_q != RCPM_IDLE);

  // Window check against the variant's own limits
  // Both bounds pass inclusively; a swapped pair fails every value.
  function automatic logic outside(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    outside = (v < lo) || (v > hi);
  endfunction

  logic [15:0] lim_lo, lim_hi;
  assign lim_lo = ctrl_mode_q ? sw_lower_q : hw_lower_q;
  assign lim_hi = ctrl_mode_q ? sw_upper_q : hw_upper_q;

  logic timed_out;
  assign timed_out = (wait_q >= timeout_q);

  // ----------------------------------------
  // Measurement sequencer
  // ----------------------------------------
  // Every wait ends early on timeout, so a dead reference never hangs
  // the sequencer; the judge state lasts one cycle and returns to idle.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      // Start strobe picks the variant
      RCPM_IDLE: begin
        if (start_wr) begin
          state_d = pwdata[RCPM_CTRL_MODE_BIT] ? RCPM_SW_SYNC : RCPM_HW_SYNC;
        end
      end
      // First capture only aligns to the reference
      RCPM_HW_SYNC: begin
        if (timed_out) begin
          state_d = RCPM_JUDGE;
        end else if (capture_flag_q) begin
          state_d = RCPM_HW_WAIT;
        end
      end
      // Second capture closes the period
      RCPM_HW_WAIT: begin
        if (timed_out || capture_flag_q) begin
          state_d = RCPM_JUDGE;
        end
      end
      // Pin mode aligns on a falling edge
      RCPM_SW_SYNC: begin
        if (timed_out) begin
          state_d = RCPM_JUDGE;
        end else if (pin_fall) begin
          state_d = RCPM_SW_RISE;
        end
      end
      // Counting starts at the following rising edge
      RCPM_SW_RISE: begin
        if (timed_out) begin
          state_d = RCPM_JUDGE;
        end else if (pin_rise) begin
          state_d = RCPM_SW_COUNT;
        end
      end
      // High time only, ended by the next falling edge
      RCPM_SW_COUNT: begin
        if (timed_out || pin_fall) begin
          state_d = RCPM_JUDGE;
        end
      end
      RCPM_JUDGE: begin
        state_d = RCPM_IDLE;
      end
    endcase
  end

  // Timeout, result flag marks a wait that expired
  // The wait counter restarts on every state change, so the limit applies
  // to each wait on its own, not to the whole run.
  logic expired_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= RCPM_IDLE;
      wait_q <= '0;
      expired_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_d != state_q || state_q == RCPM_IDLE) wait_q <= '0;
      else wait_q <= wait_q + 1'b1;
      if (state_q == RCPM_IDLE) expired_q <= 1'b0;
      else if (timed_out && state_q != RCPM_JUDGE) expired_q <= 1'b1;
    end
  end

  // Capture flag: set on event, cleared when consumed (set wins)
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      capture_flag_q <= 1'b0;
    end else if (cap_evt) begin
      capture_flag_q <= 1'b1;
    end else if (state_q == RCPM_IDLE || ((state_q == RCPM_HW_SYNC || state_q == RCPM_HW_WAIT) && capture_flag_q)) begin
      capture_flag_q <= 1'b0;
    end
  end

  // Period counter in hardware mode, cleared at the first capture; loop counter in pin mode
  // Hardware value counts cycles from one capture to the next, both
  // captures delayed alike by the synchroniser, so the latency cancels.
  // Pin mode steps the count once per six cycles of high time.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      loop_q <= '0;
      value_q <= '0;
    end else begin
      if (state_q == RCPM_HW_SYNC && capture_flag_q) begin
        cnt_q <= '0;
      end else if (state_q == RCPM_HW_WAIT) begin
        if (capture_flag_q) value_q <= cnt_q + 16'h0001;
        else cnt_q <= cnt_q + 16'h0001;
      end else if (state_q == RCPM_SW_RISE) begin
        cnt_q <= '0;
        loop_q <= '0;
      end else if (state_q == RCPM_SW_COUNT) begin
        if (pin_fall) begin
          value_q <= cnt_q;
        end else if (loop_q == RCPM_LOOP_LAST) begin
          loop_q <= '0;
          cnt_q <= cnt_q + 16'h0001;
        end else begin
          loop_q <= loop_q + 3'h1;
        end
      end
    end
  end

  // Result, control and limit registers
  // A timeout outranks the window check, as the value is then stale.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      result_q <= RCPM_RES_PASS;
      ctrl_mode_q <= 1'b0;
      ctrl_src_q <= RCPM_SRC_SUB_CLOCK;
      ctrl_pin_q <= '0;
      hw_lower_q <= RCPM_HW_LOWER_RST;
      hw_upper_q <= RCPM_HW_UPPER_RST;
      sw_lower_q <= RCPM_SW_LOWER_RST;
      sw_upper_q <= RCPM_SW_UPPER_RST;
      timeout_q <= RCPM_TIMEOUT_RST;
    end else begin
      if (state_q == RCPM_JUDGE) begin
        if (expired_q) result_q <= RCPM_RES_NOREF;
        else if (outside(value_q, lim_lo, lim_hi)) result_q <= RCPM_RES_WINDOW;
        else result_q <= RCPM_RES_PASS;
      end
      if (wr_en && !busy) begin
        unique case (offs)
          RCPM_CTRL_OFF: begin
            ctrl_mode_q <= pwdata[RCPM_CTRL_MODE_BIT];
            ctrl_src_q <= pwdata[RCPM_CTRL_SRC_LSB +: RCPM_SRC_W];
            ctrl_pin_q <= pwdata[RCPM_CTRL_PIN_LSB +: RCPM_PIN_W];
          end
          RCPM_HW_LIMITS_OFF: begin
            hw_lower_q <= pwdata[15:0];
            hw_upper_q <= pwdata[31:16];
          end
          RCPM_SW_LIMITS_OFF: begin
            sw_lower_q <= pwdata[15:0];
            sw_upper_q <= pwdata[31:16];
          end
          RCPM_TIMEOUT_OFF: timeout_q <= pwdata;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Interrupts: bit0 done, bit1 failure
  // ----------------------------------------
  logic done_evt, fail_evt;
  logic stat_wr, mask_wr;
  logic [1:0] irq_clr;
  // Write-one-to-clear; an event in the same cycle keeps its bit set
  assign stat_wr = wr_en && (offs == RCPM_IRQ_STAT_OFF);
  assign mask_wr = wr_en && (offs == RCPM_IRQ_MASK_OFF);
  assign irq_clr = stat_wr ? pwdata[1:0] : 2'h0;
  assign done_evt = (state_q == RCPM_JUDGE);
  assign fail_evt = done_evt && (expired_q || outside(value_q, lim_lo, lim_hi));
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | {fail_evt, done_evt};
      if (mask_wr) irq_mask_q <= pwdata[1:0];
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Status bit 3 shows a pending capture, bits 2:0 the sequencer state.
  // Result holds the code in bits 17:16 and the value below it.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (offs)
      RCPM_CTRL_OFF: rd_mux = {21'h0, ctrl_pin_q, 2'h0, ctrl_src_q, 2'h0, ctrl_mode_q, 1'b0};
      RCPM_STATUS_OFF: rd_mux = {28'h0, cap_pending, state_q};
      RCPM_HW_LIMITS_OFF: rd_mux = {hw_upper_q, hw_lower_q};
      RCPM_SW_LIMITS_OFF: rd_mux = {sw_upper_q, sw_lower_q};
      RCPM_TIMEOUT_OFF: rd_mux = timeout_q;
      RCPM_RESULT_OFF: rd_mux = {14'h0, result_q, value_q};
      RCPM_IRQ_STAT_OFF: rd_mux = {30'h0, irq_stat_q};
      RCPM_IRQ_MASK_OFF: rd_mux = {30'h0, irq_mask_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  // Unmapped reads return zero, even where the low byte aliases a register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= addr_ok ? rd_mux : 32'h0000_0000;
    end
  end

endmodule

/* rcpm_pkg.sv */
// Package for the reference clock period monitor: register map, fields, codes.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package rcpm_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] RCPM_CTRL_OFF = 8'h00;
  localparam logic [7:0] RCPM_STATUS_OFF = 8'h04;
  localparam logic [7:0] RCPM_HW_LIMITS_OFF = 8'h08;
  localparam logic [7:0] RCPM_SW_LIMITS_OFF = 8'h0C;
  localparam logic [7:0] RCPM_TIMEOUT_OFF = 8'h10;
  localparam logic [7:0] RCPM_RESULT_OFF = 8'h14;
  localparam logic [7:0] RCPM_IRQ_STAT_OFF = 8'h18;
  localparam logic [7:0] RCPM_IRQ_MASK_OFF = 8'h1C;

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int RCPM_CTRL_START_BIT = 0;
  localparam int RCPM_CTRL_MODE_BIT = 1;
  localparam int RCPM_CTRL_SRC_LSB = 4;
  localparam int RCPM_CTRL_PIN_LSB = 8;
  localparam int RCPM_SRC_W = 2;
  localparam int RCPM_PIN_W = 3;
  localparam int RCPM_NPINS = 8;
  localparam int RCPM_CNT_W = 16;
  localparam int RCPM_TMO_W = 32;

  // ----------------------------------------
  // Capture sources
  // ----------------------------------------
  localparam logic [1:0] RCPM_SRC_LOW_SPEED_OSC = 2'h0;
  localparam logic [1:0] RCPM_SRC_SUB_CLOCK = 2'h1;
  localparam logic [1:0] RCPM_SRC_EXT_INPUT = 2'h2;

  // ----------------------------------------
  // Result codes and reset values
  // ----------------------------------------
  localparam logic [1:0] RCPM_RES_PASS = 2'h0;
  localparam logic [1:0] RCPM_RES_WINDOW = 2'h1;
  localparam logic [1:0] RCPM_RES_NOREF = 2'h2;
  localparam logic [15:0] RCPM_HW_NOMINAL = 16'h03D0;
  localparam logic [15:0] RCPM_HW_LOWER_RST = 16'h03B0;
  localparam logic [15:0] RCPM_HW_UPPER_RST = 16'h03F0;
  localparam logic [15:0] RCPM_SW_LOWER_RST = 16'h004B;
  localparam logic [15:0] RCPM_SW_UPPER_RST = 16'h005B;
  localparam logic [31:0] RCPM_TIMEOUT_RST = 32'h0000_4000;
  localparam logic [2:0] RCPM_LOOP_CYCLES = 3'h6;
  localparam logic [2:0] RCPM_LOOP_LAST = RCPM_LOOP_CYCLES - 3'h1;

  typedef enum logic [2:0] {
    RCPM_IDLE,
    RCPM_HW_SYNC,
    RCPM_HW_WAIT,
    RCPM_SW_SYNC,
    RCPM_SW_RISE,
    RCPM_SW_COUNT,
    RCPM_JUDGE
  } rcpm_state_t;

endpackage

/* rcpm_monitor_sva.sv */
// Checker for the clock period monitor, watching its top-level ports.
// Assumes APB traffic on ref_clk and an active-high reset.
`timescale 1ns/100ps
module rcpm_monitor_sva
  import rcpm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic acc;
  logic bad;
  logic rd_res;
  // Access phase and address decode
  assign acc = psel && penable;
  assign bad = (paddr > 32'h0000_001C) || (paddr[1:0] != 2'h0);
  assign rd_res = acc && !pwrite && (paddr == {24'h0, RCPM_RESULT_OFF});
  // ----------------------------------------
  // Bus and result checks
  // ----------------------------------------
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_err_unmapped: assert property (acc && bad |-> pslverr) else $error("unmapped access without error");
  chk_err_mapped: assert property (acc && !bad |-> !pslverr) else $error("mapped access flagged as error");
  chk_unmapped_zero: assert property (acc && !pwrite && bad |-> prdata == 32'h0) else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata)) else $error("read data moved");
  chk_irq_reset: assert property ($fell(rst) |-> !irq) else $error("irq high after reset");
  chk_result_code: assert property (rd_res |-> prdata[17:16] != 2'h3) else $error("illegal result code");
  chk_state_legal: assert property (acc && !pwrite && paddr == {24'h0, RCPM_STATUS_OFF} |-> prdata[2:0] != 3'h7)
    else $error("illegal state");
  // Main scenarios reached
  cover property (acc && bad);
  cover property ($rose(irq));
  cover property (rd_res && prdata[17:16] == RCPM_RES_NOREF);
endmodule
bind rcpm_monitor rcpm_monitor_sva rcpm_monitor_sva_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq));

/* rcpm_ref_src.sv */
// Reference clock source: oscillators and candidate pins.
// Assumes times in whole ns, so edges never meet ref_clk rising edges.
`timescale 1ns/100ps
module rcpm_ref_src
  import rcpm_pkg::*;
(
  input wire logic run,
  input wire logic [31:0] hi_ns,
  input wire logic [31:0] lo_ns,
  input wire logic [RCPM_PIN_W-1:0] pin_sel,
  output logic low_speed_osc_clock,
  output logic sub_clock,
  output logic ext_capture_input,
  output logic [RCPM_NPINS-1:0] reference_input_pin
);
  logic wave = 1'b0;
  // Square wave while running, resting low when stopped
  always begin
    if (run) begin
      wave = 1'b1;
      #(hi_ns);
      wave = 1'b0;
      #(lo_ns);
    end else begin
      wave = 1'b0;
      #(2);
    end
  end
  // Every capture source carries the same wave
  assign low_speed_osc_clock = wave;
  assign sub_clock = wave;
  assign ext_capture_input = wave;
  // Only the chosen pin toggles, the rest stay low
  assign reference_input_pin = {{(RCPM_NPINS-1){1'b0}}, wave} << pin_sel;
endmodule

/* tb_rcpm_monitor.sv */
// Self-checking bench for the clock period monitor over APB.
// Assumes the bound checker and the reference source model.
`timescale 1ns/100ps
module tb_rcpm_monitor
  import rcpm_pkg::*;
;
  typedef struct {logic [31:0] lo; logic [31:0] hi; logic [31:0] m; logic e;} rcpm_note_t;
  rcpm_note_t nq[$];
  rcpm_note_t n;
  logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, hi_ns = 32'h0, lo_ns = 32'h0, prdata;
  logic pready, pslverr, irq, lso, sub, ext;
  logic [2:0] pin = 3'h0, wpin = 3'h0;
  logic [7:0] pins;
  int failures = 0, tests_run = 0, p;
  always #2.5 ref_clk = ~ref_clk;
  rcpm_monitor rcpm_monitor_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_speed_osc_clock(lso), .sub_clock(sub), .ext_capture_input(ext), .reference_input_pin(pins), .irq(irq));
  rcpm_ref_src rcpm_ref_src_inst (.run(run), .hi_ns(hi_ns), .lo_ns(lo_ns), .pin_sel(wpin),
    .low_speed_osc_clock(lso), .sub_clock(sub), .ext_capture_input(ext), .reference_input_pin(pins));
  // ----------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] lo, input logic [31:0] hi);
    tests_run++;
    if ($isunknown(s) || s < lo || s > hi) begin
      failures++;
      $display("MISMATCH %s expected %h..%h seen %h", nm, lo, hi, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] m,
    input logic e);
    nq.push_back('{lo, hi, m, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic eq(input logic [7:0] a, input logic [31:0] v);
    rd(a, v, v, 32'hFFFF_FFFF, 1'b0);
  endtask
  task automatic meas(input logic [31:0] ctl, input int hc, input int pc);
    hi_ns <= 32'(hc * 5);
    lo_ns <= 32'(pc * 5 - hc * 5);
    run <= pc > 0;
    apb(1'b1, RCPM_CTRL_OFF, ctl);
  endtask
  task automatic wirq();
    for (int i = 0; i < 20000 && irq !== 1'b1; i++) @(posedge ref_clk);
  endtask
  // Waits for the end, reads code and value, clears the events
  task automatic fin(input logic [1:0] c, input int v);
    logic [15:0] l = v ? 16'(v - 1) : 16'h0;
    logic [15:0] h = v ? 16'(v + 1) : 16'h0;
    wirq();
    rd(RCPM_RESULT_OFF, {14'h0, c, l}, {14'h0, c, h}, v ? 32'h0003_FFFF : 32'h0003_0000, 1'b0);
    apb(1'b1, RCPM_IRQ_STAT_OFF, 32'h3);
  endtask
  // Read results compared in order of issue
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && nq.size() > 0) begin
      n = nq.pop_front();
      check($sformatf("rd %h", paddr), prdata & n.m, n.lo, n.hi);
      check("pslverr", {31'h0, pslverr}, {31'h0, n.e}, {31'h0, n.e});
    end
  end
  task automatic end_of_test();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    end_of_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(2));
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    eq(RCPM_HW_LIMITS_OFF, 32'h03F0_03B0);
    eq(RCPM_SW_LIMITS_OFF, 32'h005B_004B);
    eq(RCPM_TIMEOUT_OFF, 32'h0000_4000);
    eq(RCPM_IRQ_MASK_OFF, 32'h0);
    eq(RCPM_STATUS_OFF, 32'h0);
    rd(8'h20, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'b1);
    apb(1'b1, RCPM_TIMEOUT_OFF, 32'h0000_0BB8);
    apb(1'b1, RCPM_IRQ_MASK_OFF, 32'h1);
    meas(32'h1, 550, 1100);
    wirq();
    eq(RCPM_IRQ_STAT_OFF, 32'h3);
    apb(1'b1, RCPM_IRQ_MASK_OFF, 32'h2);
    check("irq", {31'h0, irq}, 32'h1, 32'h1);
    apb(1'b1, RCPM_IRQ_MASK_OFF, 32'h0);
    check("irq", {31'h0, irq}, 32'h0, 32'h0);
    apb(1'b1, RCPM_IRQ_MASK_OFF, 32'h1);
    fin(2'h1, 1100);
    eq(RCPM_IRQ_STAT_OFF, 32'h0);
    check("irq", {31'h0, irq}, 32'h0, 32'h0);
    for (int s = 0; s < 4; s++) begin
      p = 946 + $urandom % 61;
      meas({26'h0, 2'(s), 4'h1}, p / 2, p);
      fin(2'h0, p);
    end
    meas(32'h1, 450, 900);
    apb(1'b1, RCPM_HW_LIMITS_OFF, 32'h0);
    fin(2'h1, 900);
    eq(RCPM_HW_LIMITS_OFF, 32'h03F0_03B0);
    meas(32'h1, 0, 0);
    fin(2'h2, 0);
    pin = 3'($urandom % 8);
    wpin <= pin;
    meas({21'h0, pin, 8'h03}, 498, 998);
    fin(2'h0, 83);
    meas({21'h0, pin, 8'h03}, 600, 1100);
    fin(2'h1, 100);
    wpin <= pin + 3'h1;
    meas({21'h0, pin, 8'h03}, 498, 998);
    fin(2'h2, 0);
    end_of_test();
  end
endmodule
